// *** hw/acs_ctrl.v ***
// amplifier control: i2c register slave, enable sequencing, gain start-up,
// short-circuit recovery. assumes 20 MHz clk, scl/sda from open-drain pins.
// Behaviour
// RL1 - master writes register address first with direction bit 0
// RL2 - device acknowledges slave address and register address byte
// RL3 - after repeated start with read bit, device sends addressed data
// RL4 - master ends a read with not-acknowledge then stop
// RL5 - device keeps sending bytes while master acknowledges
// RL6 - enable pin high enables amplifier, low disables it
// RL7 - master waits 10 ms after enable rise before first transaction
// RL8 - master waits 1 ms after last transaction before dropping enable
// RL9 - master holds enable low at least 5 ms
// RL10 - enable rise resets registers and clears soft shutdown
// RL11 - output stage enabled 5 ms after start-up, uninterruptible
// RL12 - hardware start begins at default fixed gain, agc after gate
// RL13 - leaving soft shutdown starts at latest fixed gain, no ramp
// RL14 - gain changes during playback ramp at attack or release rate; code ramps one step every ACS_RAMP_STEP_CYC + 1 cycles instead
// RL15 - enable low with shutdown clear holds the fixed gain
// RL16 - amp enable bit zero disables only the amplifier
// RL17 - soft shutdown bit one disables most amplifier functions
// RL18 - enable low shuts everything and restores register defaults
// RL19 - during short, low duty mode retries every 110 us
// RL20 - short flag stays set after recovery until software write
// RL21 - defaults allow audio playback without configuration
// RL22 - multi-byte read returns bytes from addressed register onward
// RL23 - device answers address bytes B0 write and B1 read
// RL24 - short flag set on over-current, cleared by writing zero
// RL25 - register pointer advances after each byte sent
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"
module acs_ctrl #(
    parameter STARTUP_CYC = `ACS_STARTUP_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire enPin,
    input wire sclIn,
    input wire sdaIn,
    input wire shortDet,
    input wire thermDet,
    input wire sigAboveGate,
    output reg sdaOut,
    output reg sdaOe,
    output reg outStageOn,
    output reg ampActive,
    output reg agcActive,
    output reg [5:0] gainNow,
    output reg lowDutyMode,
    output reg coreBiasOn
);
    localparam ST_IDLE = 6'h01;
    localparam ST_ADDR = 6'h02;
    localparam ST_RX = 6'h04;
    localparam ST_TX = 6'h08;
    localparam ST_ACKTX = 6'h10;
    localparam ST_ACKRX = 6'h20;
    // reload values are cut to the counter widths on purpose
    localparam [31:0] RETRY_FULL = `ACS_RETRY_CYC - 1;
    localparam [31:0] RAMP_FULL = `ACS_RAMP_STEP_CYC;
    localparam [7:0] GAIN_DEF = `ACS_RST_GAIN;

    wire enS;
    wire sclS;
    wire sdaS;
    reg enPrev_r;
    reg sclPrev_r;
    reg sdaPrev_r;
    reg [5:0] state_r;
    reg [7:0] shift_r;
    reg [3:0] bitCnt_r;
    reg [7:0] ptr_r;
    reg gotReg_r;
    reg isRead_r;
    reg [7:0] regs_r [1:7];
    reg [7:0] rdData;
    reg [22:0] startCnt_r;
    reg [11:0] retryCnt_r;
    reg [11:0] rampCnt_r;
    reg wasSd_r;
    reg wr_r;
    reg [7:0] wrAddr_r;
    reg [7:0] wrData_r;

    // enable pin, scl and sda cross in through three stages each
    acs_sync3 #(.RST_VAL(1'b0)) uEn (.clk(clk), .rst_n(rst_n),
        .din(enPin), .dout(enS));
    acs_sync3 #(.RST_VAL(1'b1)) uScl (.clk(clk), .rst_n(rst_n),
        .din(sclIn), .dout(sclS));
    acs_sync3 #(.RST_VAL(1'b1)) uSda (.clk(clk), .rst_n(rst_n),
        .din(sdaIn), .dout(sdaS));

    wire sclRise = sclS & ~sclPrev_r;
    wire sclFall = ~sclS & sclPrev_r;
    wire startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
    wire stopCond = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
    wire enRise = enS & ~enPrev_r;
    wire softSd = regs_r[1][`ACS_BIT_SOFTSD];
    wire ampEnBit = regs_r[1][`ACS_BIT_AMPEN];
    wire startDone = (startCnt_r == 23'h000000);

    // RL22 reads of unmapped addresses return zero
    always @* begin
        rdData = 8'h00;
        if (ptr_r >= `ACS_REG_CTRL && ptr_r <= `ACS_REG_LAST) begin
            rdData = regs_r[ptr_r[2:0]];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            enPrev_r <= 1'b0;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            enPrev_r <= enS;
            sclPrev_r <= sclS;
            sdaPrev_r <= sdaS;
        end
    end

    // serial slave; held idle while the enable pin is low
    always @(posedge clk) begin
        if (!rst_n || !enS) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            bitCnt_r <= 4'h0;
            ptr_r <= 8'h00;
            gotReg_r <= 1'b0;
            isRead_r <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            wr_r <= 1'b0;
            wrAddr_r <= 8'h00;
            wrData_r <= 8'h00;
        end else begin
            wr_r <= 1'b0;
            if (stopCond) begin
                state_r <= ST_IDLE;
                sdaOe <= 1'b0;
            end else if (startCond) begin
                state_r <= ST_ADDR;
                bitCnt_r <= 4'h0;
                gotReg_r <= 1'b0;
                sdaOe <= 1'b0;
            end else begin
                case (state_r)
                ST_ADDR, ST_RX: begin
                    if (sclRise) begin
                        shift_r <= {shift_r[6:0], sdaS};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == 4'h8) begin
                        bitCnt_r <= 4'h0;
                        if (state_r == ST_ADDR) begin
                            // RL23 match 7-bit address
                            if (shift_r[7:1] == `ACS_SLAVE_ADDR) begin
                                // RL2 ack own address
                                isRead_r <= shift_r[0];
                                sdaOut <= 1'b0;
                                sdaOe <= 1'b1;
                                state_r <= ST_ACKRX;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else if (!gotReg_r) begin
                            // RL1 first byte of a write is the pointer
                            ptr_r <= shift_r;
                            gotReg_r <= 1'b1;
                            sdaOut <= 1'b0;
                            sdaOe <= 1'b1;
                            state_r <= ST_ACKRX;
                        end else begin
                            wr_r <= 1'b1;
                            wrAddr_r <= ptr_r;
                            wrData_r <= shift_r;
                            ptr_r <= ptr_r + 8'h01;
                            sdaOut <= 1'b0;
                            sdaOe <= 1'b1;
                            state_r <= ST_ACKRX;
                        end
                    end
                end
                ST_ACKRX: begin
                    if (sclFall) begin
                        if (isRead_r) begin
                            // RL3 drive addressed data after read address
                            shift_r <= rdData;
                            sdaOut <= rdData[7];
                            sdaOe <= ~rdData[7];
                            bitCnt_r <= 4'h1;
                            state_r <= ST_TX;
                        end else begin
                            sdaOe <= 1'b0;
                            state_r <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (bitCnt_r == 4'h8) begin
                            sdaOe <= 1'b0;
                            // RL25 advance pointer per byte sent
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= ST_ACKTX;
                        end else begin
                            sdaOut <= shift_r[6];
                            sdaOe <= ~shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end
                    end
                end
                ST_ACKTX: begin
                    if (sclRise) begin
                        // RL5 continue on ack; RL4 nack ends the read
                        if (sdaS) begin
                            state_r <= ST_IDLE;
                        end else begin
                            bitCnt_r <= 4'h0;
                            state_r <= ST_ACKRX;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
                endcase
            end
        end
    end

    // register file; RL18 enable low restores defaults, RL10 on rise too
    always @(posedge clk) begin
        if (!rst_n || !enS) begin
            // RL21 defaults play audio unconfigured
            regs_r[1] <= `ACS_RST_CTRL;
            regs_r[2] <= `ACS_RST_ATTACK;
            regs_r[3] <= `ACS_RST_RELEASE;
            regs_r[4] <= `ACS_RST_HOLD;
            regs_r[5] <= `ACS_RST_GAIN;
            regs_r[6] <= `ACS_RST_LIMIT;
            regs_r[7] <= `ACS_RST_COMP;
        end else begin
            if (wr_r && wrAddr_r >= `ACS_REG_CTRL &&
                    wrAddr_r <= `ACS_REG_LAST) begin
                regs_r[wrAddr_r[2:0]] <= wrData_r;
            end
            // RL24 set wins over a write of zero in the same cycle
            if (shortDet) begin
                regs_r[1][`ACS_BIT_FAULT] <= 1'b1;
            end else if (wr_r && wrAddr_r == `ACS_REG_CTRL) begin
                // RL20 only a software write or enable low clears it
                regs_r[1][`ACS_BIT_FAULT] <=
                    regs_r[1][`ACS_BIT_FAULT] & wrData_r[`ACS_BIT_FAULT];
            end
            if (thermDet) begin
                regs_r[1][`ACS_BIT_THERM] <= 1'b1;
            end else if (wr_r && wrAddr_r == `ACS_REG_CTRL) begin
                regs_r[1][`ACS_BIT_THERM] <=
                    regs_r[1][`ACS_BIT_THERM] & wrData_r[`ACS_BIT_THERM];
            end
        end
    end

    // RL11 start-up timer cannot be cut short while enable stays high
    always @(posedge clk) begin
        if (!rst_n || !enS) begin
            startCnt_r <= 23'h000000;
            outStageOn <= 1'b0;
            coreBiasOn <= 1'b0;
        end else begin
            if (enRise) begin
                startCnt_r <= STARTUP_CYC[22:0];
            end else if (!startDone) begin
                startCnt_r <= startCnt_r - 23'h000001;
            end
            // RL17 soft shutdown drops core bias and output stage
            coreBiasOn <= ~softSd;
            // RL6 output stage only after start-up with pin high
            outStageOn <= startDone & ~enRise & ~softSd;
        end
    end

    // RL19 retry every 110 us while the short persists
    always @(posedge clk) begin
        if (!rst_n || !enS) begin
            retryCnt_r <= 12'h000;
            lowDutyMode <= 1'b0;
        end else if (shortDet) begin
            lowDutyMode <= 1'b1;
            if (retryCnt_r == 12'h000) begin
                retryCnt_r <= RETRY_FULL[11:0];
            end else begin
                retryCnt_r <= retryCnt_r - 12'h001;
            end
        end else if (lowDutyMode && retryCnt_r != 12'h000) begin
            retryCnt_r <= retryCnt_r - 12'h001;
        end else begin
            lowDutyMode <= 1'b0;
        end
    end

    // gain control
    always @(posedge clk) begin
        if (!rst_n || !enS) begin
            // RL15 pin low holds the fixed gain
            gainNow <= GAIN_DEF[5:0];
            agcActive <= 1'b0;
            ampActive <= 1'b0;
            wasSd_r <= 1'b0;
            rampCnt_r <= 12'h000;
        end else begin
            wasSd_r <= softSd;
            // RL16 amp enable bit gates amplifier only
            ampActive <= outStageOn & ampEnBit & ~lowDutyMode &
                ~regs_r[1][`ACS_BIT_THERM];
            if (enRise) begin
                // RL12 hardware start at default fixed gain
                gainNow <= regs_r[5][5:0];
                agcActive <= 1'b0;
            end else if (softSd || wasSd_r) begin
                // RL13 jump straight to latest fixed gain
                gainNow <= regs_r[5][5:0];
                agcActive <= 1'b0;
                rampCnt_r <= 12'h000;
            end else begin
                if (sigAboveGate && regs_r[1][`ACS_BIT_NGEN]) begin
                    agcActive <= 1'b1;
                end
                // RL14 ramp one step per period toward target
                if (rampCnt_r != 12'h000) begin
                    rampCnt_r <= rampCnt_r - 12'h001;
                end else if (gainNow != regs_r[5][5:0]) begin
                    rampCnt_r <= RAMP_FULL[11:0];
                    if (gainNow < regs_r[5][5:0]) begin
                        gainNow <= gainNow + 6'h01;
                    end else begin
                        gainNow <= gainNow - 6'h01;
                    end
                end
            end
        end
    end
endmodule // acs_ctrl
`default_nettype wire

// *** include/acs_defs.vh ***
// constants for the amplifier control block: slave address, register
// map, reset values and timing counts; assumes a 20 MHz core clock
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

`define ACS_CLK_HZ 20000000
`define ACS_SLAVE_ADDR 7'h58
`define ACS_REG_CTRL 8'h01
`define ACS_REG_ATTACK 8'h02
`define ACS_REG_RELEASE 8'h03
`define ACS_REG_HOLD 8'h04
`define ACS_REG_GAIN 8'h05
`define ACS_REG_LIMIT 8'h06
`define ACS_REG_COMP 8'h07
`define ACS_REG_LAST 8'h07
`define ACS_RST_CTRL 8'hC3
`define ACS_RST_ATTACK 8'h05
`define ACS_RST_RELEASE 8'h0B
`define ACS_RST_HOLD 8'h00
`define ACS_RST_GAIN 8'h06
`define ACS_RST_LIMIT 8'h3A
`define ACS_RST_COMP 8'hC2
`define ACS_BIT_AMPEN 6
`define ACS_BIT_SOFTSD 5
`define ACS_BIT_FAULT 3
`define ACS_BIT_THERM 2
`define ACS_BIT_NGEN 0
`define ACS_STARTUP_US 5000
`define ACS_STARTUP_CYC ((`ACS_STARTUP_US * (`ACS_CLK_HZ / 1000000)))
`define ACS_RETRY_US 110
`define ACS_RETRY_CYC ((`ACS_RETRY_US * (`ACS_CLK_HZ / 1000000)))
`define ACS_RAMP_STEP_CYC 2134

`endif

// *** hw/acs_sync3.v ***
// three-stage synchroniser; output changes once stages two and three agree
// assumes an asynchronous level input and one core clock
`timescale 1ns/1ps
`default_nettype none
module acs_sync3 #(
    parameter RST_VAL = 1'b1
) (
    input wire clk,
    input wire rst_n,
    input wire din,
    output reg dout
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule // acs_sync3
`default_nettype wire

// *** tb/acs_ctrl_chk.sv ***
// port-level checks for the amplifier control block
// assumes binding into acs_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_chk #(
    parameter STARTUP_CYC = 100000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enPin,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic shortDet,
    input wire logic thermDet,
    input wire logic sigAboveGate,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic outStageOn,
    input wire logic ampActive,
    input wire logic agcActive,
    input wire logic [5:0] gainNow,
    input wire logic lowDutyMode,
    input wire logic coreBiasOn
);
    logic [31:0] enCnt_r;
    // saturates so long enabled runs never wrap
    always @(posedge clk) begin
        if (!rst_n || !enPin)
            enCnt_r <= 32'h0;
        else if (enCnt_r < STARTUP_CYC)
            enCnt_r <= enCnt_r + 32'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    stage_delay_a: assert property (
        $rose(outStageOn) |-> enCnt_r >= STARTUP_CYC)
        else $error("output stage on too early");
    en_off_amp_a: assert property (!enPin [*6] |-> !ampActive)
        else $error("amplifier active with enable low");
    en_off_all_a: assert property (
        !enPin [*6] |-> !outStageOn && !coreBiasOn)
        else $error("circuits running with enable low");
    gain_hold_a: assert property (!enPin [*6] |-> gainNow == 6'h06)
        else $error("gain not at default with enable low");
    stage_bias_a: assert property (outStageOn |-> coreBiasOn)
        else $error("output stage on in soft shutdown");
    short_mode_a: assert property (
        $rose(lowDutyMode) |-> $past(shortDet) || $past(shortDet, 2))
        else $error("low duty mode without short");
    agc_gate_a: assert property (
        $rose(agcActive) |-> $past(sigAboveGate) || $past(sigAboveGate, 2))
        else $error("agc started below noise gate");
    bias_start_a: assert property (enCnt_r == 32'hA |-> coreBiasOn)
        else $error("soft shutdown not cleared at enable");
    cover property ($rose(outStageOn));
    cover property ($rose(sdaOe));
    cover property ($rose(lowDutyMode));
endmodule // acs_ctrl_chk
bind acs_ctrl acs_ctrl_chk #(.STARTUP_CYC(STARTUP_CYC)) acs_ctrl_chk_i (
    .clk(clk), .rst_n(rst_n), .enPin(enPin), .sclIn(sclIn), .sdaIn(sdaIn),
    .shortDet(shortDet), .thermDet(thermDet), .sigAboveGate(sigAboveGate),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .outStageOn(outStageOn),
    .ampActive(ampActive), .agcActive(agcActive), .gainNow(gainNow),
    .lowDutyMode(lowDutyMode), .coreBiasOn(coreBiasOn));
`default_nettype wire

// *** tb/acs_i2c_host.sv ***
// bus master model: 400 ns bit time, scl stands high between frames
// assumes a pulled-up sda built outside from sdaLow and the slave drive
`timescale 1ns/1ps
`default_nettype none
module acs_i2c_host (
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // data moves only while scl is low; it is set late because
    // the slave frees sda some 225 ns after scl falls
    task automatic bitx(input logic b, output logic r);
        #250 sdaLow = !b;
        #50 scl = 1'b1;
        #95 r = sda;
        #5 scl = 1'b0;
    endtask
    // long lead lets the slave drop its ack before a repeated start
    task automatic start();
        #300 sdaLow = 1'b0;
        #100 scl = 1'b1;
        #100 sdaLow = 1'b1;
        #100 scl = 1'b0;
    endtask
    task automatic stop();
        #50 sdaLow = 1'b1;
        #150 scl = 1'b1;
        #100 sdaLow = 1'b0;
        #100;
    endtask
    task automatic wrByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    // acknowledge all but the last byte
    task automatic rdByte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask
endmodule // acs_i2c_host
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for acs_ctrl with a bus master model
// assumes 20 MHz clk; host waits around enable edges are shortened
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int STARTUP = 50;
    localparam int HOST_WAIT = 300;
    // register defaults, first register in the top byte
    localparam logic [55:0] DEFS = 56'hC3050B00063AC2;
    logic clk, rst_n, enPin, shortDet, sigAboveGate;
    wire logic sdaOut, sdaOe, outStageOn, ampActive, agcActive, lowDutyMode;
    wire logic coreBiasOn, scl, hostLow, sda;
    wire logic [5:0] gainNow;
    int nErrors = 0;
    int numChecks = 0;
    logic [7:0] got [8];
    // pulled-up wired-and line
    assign sda = !((sdaOe && !sdaOut) || hostLow);
    acs_ctrl #(.STARTUP_CYC(STARTUP)) acs_ctrl_i (
        .clk(clk), .rst_n(rst_n), .enPin(enPin), .sclIn(scl), .sdaIn(sda),
        .shortDet(shortDet), .thermDet(1'b0), .sigAboveGate(sigAboveGate),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .outStageOn(outStageOn),
        .ampActive(ampActive), .agcActive(agcActive), .gainNow(gainNow),
        .lowDutyMode(lowDutyMode), .coreBiasOn(coreBiasOn));
    acs_i2c_host acs_i2c_host_i (.scl(scl), .sdaLow(hostLow), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic waitSig(input int sel, input logic v);
        logic [4:0] s;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            s = {coreBiasOn, lowDutyMode, agcActive, ampActive, outStageOn};
            if (s[sel] === v) return;
        end
        nErrors++;
        $display("unexpected timeout on status %0d", sel);
        wrapUp();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        acs_i2c_host_i.start();
        acs_i2c_host_i.wrByte(8'hB0, k);
        chk("write addr ack", {7'h0, k}, 8'h01);
        acs_i2c_host_i.wrByte(a, k);
        acs_i2c_host_i.wrByte(d, k);
        chk("write data ack", {7'h0, k}, 8'h01);
        acs_i2c_host_i.stop();
    endtask
    // register address written before the read
    task automatic rd(input logic [7:0] a, input int n);
        logic k;
        acs_i2c_host_i.start();
        acs_i2c_host_i.wrByte(8'hB0, k);
        acs_i2c_host_i.wrByte(a, k);
        chk("reg addr ack", {7'h0, k}, 8'h01);
        acs_i2c_host_i.start();
        acs_i2c_host_i.wrByte(8'hB1, k);
        chk("read addr ack", {7'h0, k}, 8'h01);
        for (int i = 0; i < n; i++) begin
            acs_i2c_host_i.rdByte(i == n - 1, got[i]);
        end
        acs_i2c_host_i.stop();
    endtask
    task automatic tStartup();
        int c;
        logic k;
        logic ok;
        enPin = 1'b1;
        for (c = 0; c < 2000 && outStageOn !== 1'b1; c++) @(negedge clk);
        ok = c >= STARTUP && c < STARTUP + 10;
        chk("startup delay", {7'h0, ok}, 8'h01);
        // amplifier follows the output stage one clock later
        @(negedge clk);
        chk("default amp", {7'h0, ampActive}, 8'h01);
        chk("default gain", {2'h0, gainNow}, 8'h06);
        chk("agc before gate", {7'h0, agcActive}, 8'h00);
        sigAboveGate = 1'b1;
        waitSig(2, 1'b1);
        repeat (HOST_WAIT) @(negedge clk);
        rd(8'h01, 7);
        for (int i = 0; i < 7; i++) begin
            chk("default reg", got[i], DEFS[55 - 8 * i -: 8]);
        end
        acs_i2c_host_i.start();
        acs_i2c_host_i.wrByte(8'hB2, k);
        chk("foreign addr ack", {7'h0, k}, 8'h00);
        acs_i2c_host_i.stop();
        $display("test startup done");
    endtask
    task automatic tSoft();
        wr(8'h01, 8'hE3);
        waitSig(4, 1'b0);
        wr(8'h05, 8'h0C);
        wr(8'h01, 8'hC3);
        waitSig(4, 1'b1);
        chk("gain at exit", {2'h0, gainNow}, 8'h0C);
        waitSig(0, 1'b1);
        wr(8'h01, 8'h83);
        waitSig(1, 1'b0);
        chk("bias with amp off", {7'h0, coreBiasOn}, 8'h01);
        wr(8'h01, 8'hC3);
        waitSig(1, 1'b1);
        // two steps away: first step at once, second a period later
        wr(8'h05, 8'h0E);
        repeat (100) @(negedge clk);
        chk("gain ramp step", {2'h0, gainNow}, 8'h0D);
        repeat (2200) @(negedge clk);
        chk("gain ramp end", {2'h0, gainNow}, 8'h0E);
        $display("test soft shutdown done");
    endtask
    task automatic tShort();
        shortDet = 1'b1;
        waitSig(3, 1'b1);
        shortDet = 1'b0;
        waitSig(3, 1'b0);
        rd(8'h01, 1);
        chk("fault sticky", {7'h0, got[0][3]}, 8'h01);
        wr(8'h01, 8'hC3);
        rd(8'h01, 1);
        chk("fault cleared", got[0], 8'hC3);
        $display("test short done");
    endtask
    task automatic tEnLow();
        repeat (HOST_WAIT) @(negedge clk);
        enPin = 1'b0;
        repeat (HOST_WAIT) @(negedge clk);
        chk("stage off", {7'h0, outStageOn}, 8'h00);
        chk("gain held", {2'h0, gainNow}, 8'h06);
        enPin = 1'b1;
        waitSig(0, 1'b1);
        repeat (HOST_WAIT) @(negedge clk);
        rd(8'h05, 1);
        chk("gain reg reset", got[0], 8'h06);
        $display("test enable cycle done");
    endtask
    initial begin
        rst_n = 1'b0;
        enPin = 1'b0;
        shortDet = 1'b0;
        sigAboveGate = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        tStartup();
        tSoft();
        tShort();
        tEnLow();
        wrapUp();
    end
endmodule // testbench
`default_nettype wire
